// ==== tuning_csr_pkg.sv ====
// Constants for the per-port tuning register bank of a three-port switch.
// Assumes 32-bit registers at word-aligned byte offsets in config space.
package tuning_csr_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_LINK3 = 8'h80;
    localparam logic [7:0] OFS_LINK4 = 8'h84;
    localparam logic [7:0] OFS_LINK5 = 8'h88;
    localparam logic [7:0] OFS_TLCTL = 8'h8C;
    localparam logic [7:0] OFS_PHY3 = 8'h90;

    // Reset values; port-dependent bits are added by the bank
    localparam logic [31:0] RST_LINK3 = 32'h000F0000;
    localparam logic [31:0] RST_LINK4 = 32'h00000000;
    localparam logic [31:0] RST_LINK5 = 32'h33083333;
    localparam logic [31:0] RST_TLCTL = 32'h00791094;
    localparam logic [31:0] RST_PHY3 = 32'h00008000;
    localparam logic [31:0] UP_LINK5_SET = 32'h40000000;
    localparam logic [31:0] UP_TLCTL_SET = 32'h00000800;

    // Bits that software may write
    localparam logic [31:0] SW_LINK3 = 32'hFFFFFFFF;
    localparam logic [31:0] SW_LINK5 = 32'hC0000000;
    localparam logic [31:0] SW_TLCTL = 32'h00000060;

    // Implemented (non-reserved) bits; reserved bits read as zero
    localparam logic [31:0] IMPL_TLCTL = 32'hBFFF1FFF;
    localparam logic [31:0] IMPL_PHY3 = 32'hFFFF807F;
    // Bits the serial management paths may not override
    localparam logic [31:0] SER_DENY_TLCTL = 32'h00000040;

    // Field positions
    localparam int LINK5_CFG_KEEP = 11;
    localparam int LINK5_RATE_CTL = 30;
    localparam int LINK5_GEN1_ONLY = 31;
    localparam int TL_MW_PASS_OFF = 5;
    localparam int TL_RO_RULE_OFF = 6;
    localparam int TL_CNT_LO = 8;
    localparam int TL_CNT_HI = 9;
    localparam int TL_PORT_OFF = 10;
    localparam int TL_RST_SEL = 11;
    localparam int TL_RETRAIN_OFF = 16;
    localparam int PHY3_LANE_HI = 6;
    localparam int PHY3_DELTA_LO = 15;

    // Port count and the index of the upstream port
    localparam int NUM_PORTS = 3;
    localparam int UP_PORT = 0;

    // Source of a default override
    typedef enum logic [1:0] {SRC_SMBUS, SRC_I2C, SRC_EEPROM} ovr_src_e;

endpackage

// ==== tuning_port_bank.sv ====
// One port's copy of the five tuning registers.
// Assumes writes arrive already decoded to this port, on clk_sys.
`timescale 1ns/100ps
module tuning_port_bank #(
    parameter bit UPSTREAM = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Software write
    input wire logic sw_wr,
    input wire logic [7:0] sw_addr,
    input wire logic [3:0] sw_be,
    input wire logic [31:0] sw_wdata,
    // Default override write
    input wire logic ovr_wr,
    input wire tuning_csr_pkg::ovr_src_e ovr_src,
    input wire logic [7:0] ovr_addr,
    input wire logic [31:0] ovr_wdata,
    // Stored words
    output logic [31:0] link3,
    output logic [31:0] link4,
    output logic [31:0] link5,
    output logic [31:0] tlctl,
    output logic [31:0] phy3
);
    import tuning_csr_pkg::*;

    // Port-specific reset values
    localparam logic [31:0] RST5 = UPSTREAM ? (RST_LINK5 | UP_LINK5_SET)
                                            : RST_LINK5;
    localparam logic [31:0] RSTT = UPSTREAM ? (RST_TLCTL | UP_TLCTL_SET)
                                            : RST_TLCTL;

    // Merge new data into old under a bit mask
    function automatic logic [31:0] merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [31:0] msk);
        merge = (old_v & ~msk) | (new_v & msk);
    endfunction

    // Expand byte enables to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // Serial paths cannot touch the relaxed-ordering bit
    wire logic ser_src = (ovr_src != SRC_EEPROM);
    wire logic [31:0] ovr_tl_mask = ser_src ? (IMPL_TLCTL & ~SER_DENY_TLCTL)
                                            : IMPL_TLCTL;
    wire logic [31:0] swm = be_mask(sw_be);

    // Per-register write strobes
    wire logic o3 = ovr_wr && (ovr_addr == OFS_LINK3);
    wire logic o4 = ovr_wr && (ovr_addr == OFS_LINK4);
    wire logic o5 = ovr_wr && (ovr_addr == OFS_LINK5);
    wire logic ot = ovr_wr && (ovr_addr == OFS_TLCTL);
    wire logic op = ovr_wr && (ovr_addr == OFS_PHY3);
    wire logic s3 = sw_wr && (sw_addr == OFS_LINK3);
    wire logic s5 = sw_wr && (sw_addr == OFS_LINK5);
    wire logic st = sw_wr && (sw_addr == OFS_TLCTL);

    // Storage; an override wins over a software write in the same cycle
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            link3 <= RST_LINK3;
            link4 <= RST_LINK4;
            link5 <= RST5;
            tlctl <= RSTT;
            phy3 <= RST_PHY3;
        end
        else
        begin
            // Override paths replace defaults of every field, except the relaxed-ordering bit from serial sources
            if (o3) link3 <= ovr_wdata;
            else if (s3) link3 <= merge(link3, sw_wdata, SW_LINK3 & swm);
            if (o4) link4 <= ovr_wdata;
            if (o5) link5 <= ovr_wdata;
            else if (s5) link5 <= merge(link5, sw_wdata, SW_LINK5 & swm);
            // Reserved bits are never stored, so their content is kept
            if (ot) tlctl <= merge(tlctl, ovr_wdata, ovr_tl_mask);
            else if (st) tlctl <= merge(tlctl, sw_wdata, SW_TLCTL & swm);
            if (op) phy3 <= ovr_wdata & IMPL_PHY3;
        end
    end
endmodule

// ==== switch_port_tuning_csrs.sv ====
// Tuning register banks for all three switch ports, their read port,
// and the decoded controls they drive.
// Assumes config accesses and override writes arrive on clk_sys,
// and that the link-down level comes from logic on the same clock.
// Each port keeps a full copy of every word; fields set by the
// upstream port alone are taken from port 0's copy and nowhere else.
// Override writes come from a management master that runs on clk_sys.
`timescale 1ns/100ps
module switch_port_tuning_csrs (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Config space access
    input wire logic [1:0] cfg_port,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    // Default override from SMBus, I2C or EEPROM autoload
    input wire logic ovr_wr,
    input wire tuning_csr_pkg::ovr_src_e ovr_src,
    input wire logic [1:0] ovr_port,
    input wire logic [7:0] ovr_addr,
    input wire logic [31:0] ovr_wdata,
    // Upstream link state
    input wire logic up_link_down,
    output logic cfg_reset_req,
    // Per-port controls
    output logic [2:0] port_disabled,
    output logic [2:0] rate_change_control,
    output logic [2:0] first_gen_only,
    output logic [5:0] rate_change_attempt_count,
    output logic [20:0] lane_mode,
    // Global controls from the upstream copy
    output logic keep_cfg_on_link_down,
    output logic up_reset_select,
    output logic relaxed_order_off,
    output logic memory_write_passing_off,
    output logic phy_retrain_off,
    output logic [16:0] phy_delta_value
);
    import tuning_csr_pkg::*;

    // Stored words of each port
    // The banks hold the flops; these arrays only name their outputs
    logic [31:0] w3 [NUM_PORTS];
    logic [31:0] w4 [NUM_PORTS];
    logic [31:0] w5 [NUM_PORTS];
    logic [31:0] wt [NUM_PORTS];
    logic [31:0] wp [NUM_PORTS];

    // Read data and control state
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic rvalid_q;
    logic link_down_q;
    logic reset_req_q;
    // Registered per-port controls: disable, rate change, first gen
    localparam int NUM_CTL = 3;
    logic [NUM_PORTS-1:0] ctl_q [NUM_CTL];

    // One bank per port, upstream first
    // The upstream bank differs only in its port-dependent reset values
    for (genvar i = 0; i < NUM_PORTS; i++)
    begin : g_bank
        tuning_port_bank #(
            .UPSTREAM(i == UP_PORT)
        ) u_bank (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .sw_wr(cfg_wr && (cfg_port == 2'(i))),
            .sw_addr(cfg_addr),
            .sw_be(cfg_be),
            .sw_wdata(cfg_wdata),
            .ovr_wr(ovr_wr && (ovr_port == 2'(i))),
            .ovr_src(ovr_src),
            .ovr_addr(ovr_addr),
            .ovr_wdata(ovr_wdata),
            .link3(w3[i]),
            .link4(w4[i]),
            .link5(w5[i]),
            .tlctl(wt[i]),
            .phy3(wp[i])
        );
    end

    // Read selection; unmapped offsets and ports read zero
    wire logic port_ok = (cfg_port < 2'(NUM_PORTS));
    wire logic [1:0] rp = port_ok ? cfg_port : 2'h0;
    // Absent port is steered to index 0 so the arrays are never overrun
    always_comb
    begin
        rdata_d = 32'h00000000;
        if (port_ok)
        begin
            unique case (cfg_addr)
                OFS_LINK3: rdata_d = w3[rp];
                OFS_LINK4: rdata_d = w4[rp];
                OFS_LINK5: rdata_d = w5[rp];
                // Reserved bits are masked again on the way out
                OFS_TLCTL: rdata_d = wt[rp] & IMPL_TLCTL;
                OFS_PHY3: rdata_d = wp[rp] & IMPL_PHY3;
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    // Read data is registered; valid one cycle after the request
    // Data holds between reads, so a slow master may collect it late
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_q <= 32'h00000000;
            rvalid_q <= 1'b0;
        end
        else
        begin
            // Valid follows every read strobe; data moves only on a read
            rvalid_q <= cfg_rd;
            if (cfg_rd) rdata_q <= rdata_d;
        end
    end
    assign cfg_rdata = rdata_q;
    assign cfg_rvalid = rvalid_q;

    // Global link-down policy from the upstream copy
    wire logic keep_cfg = w5[UP_PORT][LINK5_CFG_KEEP];
    wire logic link_down_rise = up_link_down && !link_down_q;

    // Request a config reset on upstream link down unless told to keep
    // Only the rising edge counts: a link that stays down asks once,
    // and a second loss needs the link to come back up first
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            link_down_q <= 1'b0;
            reset_req_q <= 1'b0;
        end
        else
        begin
            // Last level, to find the rising edge of a loss
            link_down_q <= up_link_down;
            reset_req_q <= link_down_rise && !keep_cfg;
        end
    end
    assign cfg_reset_req = reset_req_q;

    // Per-port decoded controls, gathered for registering
    // Port disable from the control word, rate bits from link word five
    // These feed the registered outputs below, one bit per port
    logic [NUM_PORTS-1:0] dis_w;
    logic [NUM_PORTS-1:0] rate_w;
    logic [NUM_PORTS-1:0] gen1_w;
    always_comb
    begin
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            dis_w[i] = wt[i][TL_PORT_OFF];
            rate_w[i] = w5[i][LINK5_RATE_CTL];
            gen1_w[i] = w5[i][LINK5_GEN1_ONLY];
        end
    end

    // Control outputs come from flip-flops
    // One cycle of lag after a write; consumers see a glitch-free level
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            // Every registered per-port control is off while in reset
            for (int k = 0; k < NUM_CTL; k++) ctl_q[k] <= '0;
        end
        else
        begin
            ctl_q[0] <= dis_w;
            ctl_q[1] <= rate_w;
            ctl_q[2] <= gen1_w;
        end
    end
    assign port_disabled = ctl_q[0];
    assign rate_change_control = ctl_q[1];
    assign first_gen_only = ctl_q[2];

    // Attempt count and lane mode are per-port fields
    // Each port's slice is read straight from that port's own copy
    for (genvar j = 0; j < NUM_PORTS; j++)
    begin : g_lane
        assign rate_change_attempt_count[2*j +: 2] =
            wt[j][TL_CNT_HI:TL_CNT_LO];
        assign lane_mode[7*j +: 7] = wp[j][PHY3_LANE_HI:0];
    end

    // Global fields come only from the upstream copy
    // Downstream copies of these bits are stored and read back, but
    // they steer nothing in the switch
    assign keep_cfg_on_link_down = keep_cfg;
    assign up_reset_select = wt[UP_PORT][TL_RST_SEL];
    assign relaxed_order_off = wt[UP_PORT][TL_RO_RULE_OFF];
    assign memory_write_passing_off = wt[UP_PORT][TL_MW_PASS_OFF];
    assign phy_retrain_off = wt[UP_PORT][TL_RETRAIN_OFF];
    assign phy_delta_value = wp[UP_PORT][31:PHY3_DELTA_LO];
endmodule

// ==== tuning_csrs_chk.sv ====
// Port checker for the tuning register bank.
// Assumes one clock domain; bound onto the bank's top module.
`timescale 1ns/100ps
module tuning_csrs_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Config access
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [31:0] cfg_rdata,
    // Override and link state
    input wire logic ovr_wr,
    input wire tuning_csr_pkg::ovr_src_e ovr_src,
    input wire logic up_link_down,
    input wire logic cfg_reset_req,
    // Decoded controls
    input wire logic [2:0] port_disabled,
    input wire logic [20:0] lane_mode,
    input wire logic keep_cfg_on_link_down,
    input wire logic relaxed_order_off,
    input wire logic phy_retrain_off
);
    import tuning_csr_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Link loss asks for a config reset unless keep is set
    chk_link_down_reset: assert property ($rose(up_link_down) &&
        !keep_cfg_on_link_down |=> cfg_reset_req) else $error("no req");
    chk_link_down_keep: assert property ($rose(up_link_down) &&
        keep_cfg_on_link_down |=> !cfg_reset_req) else $error("bad req");
    chk_reset_req_pulse: assert property (cfg_reset_req |=>
        !cfg_reset_req) else $error("req too long");
    // Serial paths cannot move the ordering control
    chk_serial_ro_locked: assert property (ovr_wr && !cfg_wr &&
        ovr_src != SRC_EEPROM |=> $stable(relaxed_order_off))
        else $error("ordering bit moved");
    // Read-only fields move only after an override
    chk_port_off_source: assert property ($changed(port_disabled)
        |-> $past(ovr_wr, 2)) else $error("port off moved");
    chk_lane_mode_source: assert property ($changed(lane_mode)
        |-> $past(ovr_wr)) else $error("lane mode moved");
    chk_retrain_source: assert property ($changed(phy_retrain_off)
        |-> $past(ovr_wr)) else $error("retrain moved");
    // Reserved bits always read as zero
    chk_reserved_tl_zero: assert property (cfg_rd &&
        cfg_addr == OFS_TLCTL |=> (cfg_rdata & ~IMPL_TLCTL) == 32'h0)
        else $error("tl reserved set");
    chk_reserved_phy_zero: assert property (cfg_rd &&
        cfg_addr == OFS_PHY3 |=> (cfg_rdata & ~IMPL_PHY3) == 32'h0)
        else $error("phy reserved set");
endmodule
bind switch_port_tuning_csrs tuning_csrs_chk u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .cfg_addr(cfg_addr),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .ovr_wr(ovr_wr), .ovr_src(ovr_src), .up_link_down(up_link_down),
    .cfg_reset_req(cfg_reset_req), .port_disabled(port_disabled),
    .lane_mode(lane_mode), .keep_cfg_on_link_down(keep_cfg_on_link_down),
    .relaxed_order_off(relaxed_order_off),
    .phy_retrain_off(phy_retrain_off));

// ==== default_loader.sv ====
// Model of the default loader: SMBus, I2C or EEPROM master.
// Assumes the bank samples override writes on clk_sys rising edges.
`timescale 1ns/100ps
module default_loader (
    // Clock
    input wire logic clk_sys,
    // Override bus toward the bank
    output logic ovr_wr,
    output tuning_csr_pkg::ovr_src_e ovr_src,
    output logic [1:0] ovr_port,
    output logic [7:0] ovr_addr,
    output logic [31:0] ovr_wdata
);
    import tuning_csr_pkg::*;
    // Idle bus at time zero
    initial
    begin
        ovr_wr = 1'b0;
        ovr_src = SRC_EEPROM;
        ovr_port = 2'h0;
        ovr_addr = 8'h00;
        ovr_wdata = 32'h0;
    end
    // One whole-word default load, taken at one edge
    task automatic load(input ovr_src_e s, input logic [1:0] p,
        input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        ovr_wr <= 1'b1;
        ovr_src <= s;
        ovr_port <= p;
        ovr_addr <= a;
        ovr_wdata <= d;
        @(posedge clk_sys);
        ovr_wr <= 1'b0;
        ovr_wdata <= ~d; // Stale data must not look valid
        #1;
    endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the tuning register bank.
// Assumes a 50 MHz clk_sys and the default loader model.
`timescale 1ns/100ps
module tb;
    import tuning_csr_pkg::*;
    // Bench state and design signals
    int mismatches, checks_done;
    logic clk_sys, nrst, cfg_wr, cfg_rd, cfg_rvalid, up_link_down;
    logic ovr_wr, cfg_reset_req, keep, up_rsel, ro_off, mw_off, rt_off;
    logic [1:0] cfg_port, ovr_port;
    logic [2:0] port_dis, rc_ctl, gen1;
    logic [3:0] cfg_be;
    logic [5:0] cnt;
    logic [7:0] cfg_addr, ovr_addr;
    logic [16:0] delta;
    logic [20:0] lane;
    logic [31:0] cfg_wdata, cfg_rdata, ovr_wdata;
    ovr_src_e ovr_src;
    switch_port_tuning_csrs u_dut (.clk_sys(clk_sys), .nrst(nrst),
        .cfg_port(cfg_port), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .ovr_wr(ovr_wr),
        .ovr_src(ovr_src), .ovr_port(ovr_port), .ovr_addr(ovr_addr),
        .ovr_wdata(ovr_wdata), .up_link_down(up_link_down),
        .cfg_reset_req(cfg_reset_req), .port_disabled(port_dis),
        .rate_change_control(rc_ctl), .first_gen_only(gen1),
        .rate_change_attempt_count(cnt), .lane_mode(lane),
        .keep_cfg_on_link_down(keep), .up_reset_select(up_rsel),
        .relaxed_order_off(ro_off), .memory_write_passing_off(mw_off),
        .phy_retrain_off(rt_off), .phy_delta_value(delta));
    default_loader u_ld (.clk_sys(clk_sys), .ovr_wr(ovr_wr),
        .ovr_src(ovr_src), .ovr_port(ovr_port), .ovr_addr(ovr_addr),
        .ovr_wdata(ovr_wdata));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Config write, settled after its edge
    task automatic wr(input logic [1:0] p, input logic [7:0] a,
        input logic [3:0] b, input logic [31:0] d);
        @(posedge clk_sys);
        {cfg_wr, cfg_port, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, p, a, b, d};
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
        #1;
    endtask
    // Config read with one-cycle answer
    task automatic rd(input logic [1:0] p, input logic [7:0] a,
        input logic [31:0] e);
        @(posedge clk_sys);
        {cfg_rd, cfg_port, cfg_addr} <= {1'b1, p, a};
        @(posedge clk_sys);
        cfg_rd <= 1'b0;
        #1;
        chk({31'h0, cfg_rvalid}, 32'h1);
        chk(cfg_rdata, e);
    endtask
    // Upstream link loss, expecting the given request level
    task automatic link_drop(input logic e);
        @(posedge clk_sys);
        up_link_down <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk({31'h0, cfg_reset_req}, {31'h0, e});
        @(posedge clk_sys);
        up_link_down <= 1'b0;
        #1;
        chk({31'h0, cfg_reset_req}, 32'h0);
    endtask
    // Reset values, port 3 and an unmapped offset
    task automatic t_reset;
        rd(2'h0, OFS_LINK3, 32'h000F0000);
        rd(2'h0, OFS_LINK4, 32'h0);
        rd(2'h0, OFS_LINK5, 32'h73083333);
        rd(2'h1, OFS_LINK5, 32'h33083333);
        rd(2'h0, OFS_TLCTL, 32'h00791894);
        rd(2'h2, OFS_TLCTL, 32'h00791094);
        rd(2'h1, OFS_PHY3, 32'h00008000);
        rd(2'h3, OFS_TLCTL, 32'h0);
        rd(2'h0, 8'h94, 32'h0);
        chk({26'h0, rc_ctl, rt_off, up_rsel, keep}, 32'h0E);
        chk({15'h0, delta}, 32'h1);
    endtask
    // Software writes: masks, read-only bits, global copy
    task automatic t_sw;
        wr(2'h0, OFS_LINK3, 4'h5, 32'hFFFFFFFF);
        rd(2'h0, OFS_LINK3, 32'h00FF00FF);
        wr(2'h1, OFS_LINK5, 4'h8, 32'hFFFFFFFF);
        rd(2'h1, OFS_LINK5, 32'hF3083333);
        chk({26'h0, gen1, rc_ctl}, 32'h13);
        wr(2'h1, OFS_TLCTL, 4'hF, 32'hFFFFFFFF);
        rd(2'h1, OFS_TLCTL, 32'h007910F4);
        chk({27'h0, port_dis, ro_off, mw_off}, 32'h0);
        wr(2'h0, OFS_TLCTL, 4'hF, 32'h00000020);
        chk({30'h0, ro_off, mw_off}, 32'h1);
        wr(2'h0, OFS_TLCTL, 4'hF, 32'h0);
    endtask
    // Default overrides from every source
    task automatic t_ovr;
        u_ld.load(SRC_SMBUS, 2'h0, OFS_TLCTL, 32'h00000040);
        rd(2'h0, OFS_TLCTL, 32'h0);
        for (int s = 0; s < 3; s++)
        begin
            u_ld.load(ovr_src_e'(s), 2'h0, OFS_LINK4, 32'h11 << s);
            rd(2'h0, OFS_LINK4, 32'h11 << s);
        end
        u_ld.load(SRC_EEPROM, 2'h0, OFS_TLCTL, 32'hFFFFFFFF);
        rd(2'h0, OFS_TLCTL, 32'hBFFF1FFF);
        chk({27'h0, port_dis, ro_off, rt_off}, 32'h7);
        u_ld.load(SRC_I2C, 2'h2, OFS_TLCTL, 32'h00000300);
        chk({26'h0, cnt}, 32'h33);
        u_ld.load(SRC_EEPROM, 2'h1, OFS_PHY3, 32'hFFFFFFFF);
        rd(2'h1, OFS_PHY3, 32'hFFFF807F);
        chk({lane, delta[10:0]}, {21'h3F80, 11'h1});
        u_ld.load(SRC_EEPROM, 2'h0, OFS_PHY3, 32'h00018000);
        chk({15'h0, delta}, 32'h3);
    endtask
    // Clock source
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Main sequence
    initial
    begin
        {nrst, cfg_wr, cfg_rd, up_link_down} = 4'h0;
        {cfg_port, cfg_addr, cfg_be, cfg_wdata} = 46'h0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        t_reset;
        t_sw;
        t_ovr;
        link_drop(1'b1);
        u_ld.load(SRC_I2C, 2'h0, OFS_LINK5, 32'h00000800);
        link_drop(1'b0);
        wrap_up;
    end
    // Hang guard
    initial
    begin
        #200000;
        mismatches++;
        wrap_up;
    end
    // Verdict
    task automatic wrap_up;
        if (mismatches == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
endmodule
